// ===== src/cxc_pkg.sv
package cxc_pkg;
	// ---------------------------------------------------------------
	// Operation classes on the issue port
	// ---------------------------------------------------------------
	localparam logic [3:0] OP_ALU = 4'h0;
	localparam logic [3:0] OP_SHIFT = 4'h1;
	localparam logic [3:0] OP_BIT = 4'h2;
	localparam logic [3:0] OP_MUL = 4'h3;
	localparam logic [3:0] OP_DIV = 4'h4;
	localparam logic [3:0] OP_BRANCH = 4'h5;
	localparam logic [3:0] OP_PUSH = 4'h6;
	localparam logic [3:0] OP_POP = 4'h7;
	localparam logic [3:0] OP_MAC = 4'h8;
	// Function selects, meaning depends on the class
	localparam logic [1:0] FN_ADD = 2'h0;
	localparam logic [1:0] FN_SUB = 2'h1;
	localparam logic [1:0] FN_AND = 2'h2;
	localparam logic [1:0] FN_OR = 2'h3;
	localparam logic [1:0] FN_SHL = 2'h0;
	localparam logic [1:0] FN_SHR = 2'h1;
	localparam logic [1:0] FN_ROL = 2'h2;
	localparam logic [1:0] FN_ASHR = 2'h3;
	localparam logic [1:0] FN_MAC_MUL = 2'h0;
	localparam logic [1:0] FN_MAC_ACC = 2'h1;
	localparam logic [1:0] FN_MAC_ADD32 = 2'h2;
	// ---------------------------------------------------------------
	// Cycle counts per class
	// ---------------------------------------------------------------
	localparam logic [4:0] CYC_ONE = 5'h01;
	localparam logic [4:0] CYC_BRANCH = 5'h02;
	localparam logic [4:0] CYC_JC_HIT = 5'h01;
	localparam logic [4:0] CYC_MUL = 5'h05;
	localparam logic [4:0] CYC_DIV = 5'h0A;
	// ---------------------------------------------------------------
	// Sizes and reset values
	// ---------------------------------------------------------------
	localparam int PIPE_STAGES = 4;
	localparam int GPR_COUNT = 16;
	localparam int STACK_BYTES = 2048;
	localparam logic [15:0] STACK_BASE = 16'hF000;
	localparam logic [15:0] STACK_MASK = 16'h07FF;
	localparam logic [15:0] SP_RST = 16'hF7FE;
	localparam logic [15:0] CP_RST = 16'hFC00;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam int MAC_ACC_W = 40;

	typedef enum logic [1:0] {
		CXC_IDLE = 2'b01,
		CXC_BUSY = 2'b10
	} cxc_state_t;
endpackage

// ===== src/cxc_core.sv
`timescale 1ns/1ns
// Summary of operation
// - Instructions flow through four pipeline stages around a 16-bit ALU.
// - Multiply, divide, bit-mask generation and barrel shifting have their own logic.
// - Shifts and rotates of any distance, like most instructions, take one cycle.
// - A taken branch holds the pipeline two cycles unless the jump cache serves it.
// - A 16 by 16 multiply delivers its result after five cycles.
// - A 32 by 16 divide delivers its result after ten cycles.
// - A jump repeated in a loop hits the jump cache and takes one cycle.
// - The sixteen general registers live in internal work RAM, not in flip-flops.
// - Each general register address is the context base pointer plus twice its index.
// - Banks are limited only by RAM size and may overlap freely.
// - The system stack spans at most 2048 bytes of RAM, reached through the stack pointer.
// - A push compares the decremented stack pointer with the upper bound only, a pop the incremented one with the lower bound only.
// - Up to two operands per cycle are handed to the multiply-accumulate coprocessor.
// - The coprocessor has a multiply-accumulate unit and a repeat unit.
// - The coprocessor adds multiply, multiply-accumulate and 32-bit signed add.
module cxc_core
	import cxc_pkg::*;
#(
	parameter int DW = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic issue_valid,
	output logic issue_ready,
	input wire logic [3:0] issue_op,
	input wire logic [1:0] issue_fn,
	input wire logic [DW-1:0] src_a,
	input wire logic [DW-1:0] src_b,
	input wire logic [DW-1:0] src_hi,
	input wire logic [3:0] shift_amt,
	input wire logic [3:0] dst_sel,
	input wire logic [3:0] mac_repeat,
	input wire logic br_taken,
	input wire logic [15:0] br_pc,
	input wire logic [15:0] br_target,
	input wire logic cp_wr,
	input wire logic [15:0] cp_wdata,
	input wire logic sp_wr,
	input wire logic [15:0] sp_wdata,
	input wire logic [15:0] stack_upper_bound,
	input wire logic [15:0] stack_lower_bound,
	input wire logic stk_flag_clr,
	output logic [15:0] context_base_pointer,
	output logic [15:0] stack_pointer,
	output logic stk_ovf_flag,
	output logic stk_unf_flag,
	output logic res_valid,
	output logic [DW-1:0] res_data,
	output logic [DW-1:0] res_hi,
	output logic br_redirect,
	output logic [15:0] br_dest,
	output logic ram_we,
	output logic ram_re,
	output logic [15:0] ram_addr,
	output logic [DW-1:0] ram_wdata,
	output logic mac_strobe,
	output logic [DW-1:0] mac_op1,
	output logic [DW-1:0] mac_op2,
	output logic [MAC_ACC_W-1:0] mac_acc,
	output logic [PIPE_STAGES-1:0] stage_valid
);
	// ---------------------------------------------------------------
	// Decode and latency selection
	// ---------------------------------------------------------------
	cxc_state_t state_q, state_d;
	logic [4:0] cnt_q;
	logic [15:0] cp_q, sp_q;
	logic jc_valid_q;
	logic [15:0] jc_tag_q;
	logic [DW-1:0] pend_res_q, pend_hi_q;
	logic pend_we_q, pend_br_q, pend_mac_q;
	logic [1:0] pend_fn_q;
	logic [15:0] pend_addr_q, pend_dest_q;
	logic ovf_q, unf_q;
	logic [PIPE_STAGES-1:0] stage_q;

	wire accept = issue_valid && issue_ready;
	wire busy = (state_q == CXC_BUSY);
	wire is_mac = (issue_op == OP_MAC);
	wire jc_hit = jc_valid_q && (jc_tag_q == br_pc);
	wire br_go = (issue_op == OP_BRANCH) && br_taken;
	wire [4:0] br_lat = jc_hit ? CYC_JC_HIT : CYC_BRANCH;
	wire [4:0] mac_lat = CYC_ONE + {1'b0, mac_repeat};
	wire [4:0] lat = (issue_op == OP_MUL) ? CYC_MUL :
		(issue_op == OP_DIV) ? CYC_DIV :
		br_go ? br_lat : is_mac ? mac_lat : CYC_ONE;
	wire finish = (accept && lat == CYC_ONE) || (busy && cnt_q == 5'h01);

	// Issue waits out every multi-cycle op so later ones see its result
	assign issue_ready = !busy;

	// ---------------------------------------------------------------
	// Execution units
	// ---------------------------------------------------------------
	// Barrel shifter: any distance in one pass, no iteration
	wire [31:0] rol_w = {src_a, src_a} << shift_amt;
	wire [DW-1:0] sh_res = (issue_fn == FN_SHL) ? src_a << shift_amt :
		(issue_fn == FN_SHR) ? src_a >> shift_amt :
		(issue_fn == FN_ROL) ? rol_w[31:16] :
		DW'($signed(src_a) >>> shift_amt);
	wire [DW-1:0] bmask = DW'(1) << shift_amt;
	wire [DW-1:0] bit_res = issue_fn[0] ? (src_a & ~bmask) : (src_a | bmask);
	wire [DW-1:0] alu_res = (issue_fn == FN_ADD) ? src_a + src_b :
		(issue_fn == FN_SUB) ? src_a - src_b :
		(issue_fn == FN_AND) ? src_a & src_b : src_a | src_b;
	wire [31:0] mul_u = src_a * src_b;
	// Operands are widened first, or the signed product loses its high half
	wire signed [31:0] mul_sa = 32'($signed(src_a));
	wire signed [31:0] mul_sb = 32'($signed(src_b));
	wire [31:0] mul_s = 32'(mul_sa * mul_sb);
	wire [31:0] mul_res = issue_fn[0] ? mul_s : mul_u;
	wire [31:0] dividend = {src_hi, src_a};
	wire div_zero = (src_b == '0);
	// A zero divisor gives all ones and returns the low dividend word
	wire [31:0] quot = div_zero ? 32'hFFFFFFFF : dividend / {16'h0000, src_b};
	wire [31:0] rem = div_zero ? {16'h0000, src_a} : dividend % {16'h0000, src_b};
	wire [DW-1:0] ex_res = (issue_op == OP_SHIFT) ? sh_res :
		(issue_op == OP_BIT) ? bit_res :
		(issue_op == OP_MUL) ? mul_res[15:0] :
		(issue_op == OP_DIV) ? quot[15:0] : alu_res;
	wire [DW-1:0] ex_hi = (issue_op == OP_MUL) ? mul_res[31:16] :
		(issue_op == OP_DIV) ? rem[15:0] : '0;
	wire ex_we = (issue_op <= OP_DIV);

	// ---------------------------------------------------------------
	// Register bank and stack addressing
	// ---------------------------------------------------------------
	// Bank placement is unchecked, so banks may overlap for parameter passing
	wire [15:0] cp_next = cp_wdata & ~16'h0001;
	wire [15:0] gpr_addr = cp_q + {11'h000, dst_sel, 1'b0};
	// Stack offset wraps inside its window so it never leaves the region
	wire [15:0] sp_dec = STACK_BASE | ((sp_q - WORD_STEP) & STACK_MASK);
	wire [15:0] sp_inc = STACK_BASE | ((sp_q + WORD_STEP) & STACK_MASK);
	wire do_push = accept && issue_op == OP_PUSH;
	wire do_pop = accept && issue_op == OP_POP;
	wire ovf_ev = do_push && (sp_dec < stack_upper_bound);
	wire unf_ev = do_pop && (sp_inc > stack_lower_bound);
	wire [15:0] sp_d = sp_wr ? sp_wdata : do_push ? sp_dec : do_pop ? sp_inc : sp_q;

	// ---------------------------------------------------------------
	// Coprocessor datapath
	// ---------------------------------------------------------------
	wire [DW-1:0] m_a = accept ? src_a : mac_op1;
	wire [DW-1:0] m_b = accept ? src_b : mac_op2;
	wire [1:0] m_fn = accept ? issue_fn : pend_fn_q;
	wire mac_step = (accept && is_mac) || (busy && pend_mac_q);
	wire signed [31:0] m_sa = 32'($signed(m_a));
	wire signed [31:0] m_sb = 32'($signed(m_b));
	wire [MAC_ACC_W-1:0] m_prod = MAC_ACC_W'(m_sa * m_sb);
	wire [MAC_ACC_W-1:0] m_w32 = MAC_ACC_W'($signed({m_b, m_a}));
	wire [MAC_ACC_W-1:0] acc_d = (m_fn == FN_MAC_MUL) ? m_prod :
		(m_fn == FN_MAC_ACC) ? mac_acc + m_prod : mac_acc + m_w32;

	// ---------------------------------------------------------------
	// Control state
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CXC_IDLE: if (accept && lat != CYC_ONE) state_d = CXC_BUSY;
			CXC_BUSY: if (cnt_q == 5'h01) state_d = CXC_IDLE;
			default: state_d = CXC_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= CXC_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= accept ? lat - 5'h01 : busy ? cnt_q - 5'h01 : cnt_q;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_res_q <= '0;
			pend_hi_q <= '0;
			pend_we_q <= 1'b0;
			pend_br_q <= 1'b0;
			pend_mac_q <= 1'b0;
			pend_fn_q <= '0;
			pend_addr_q <= '0;
			pend_dest_q <= '0;
		end else if (accept) begin
			pend_res_q <= ex_res;
			pend_hi_q <= ex_hi;
			pend_we_q <= ex_we;
			pend_br_q <= br_go;
			pend_mac_q <= is_mac;
			pend_fn_q <= issue_fn;
			pend_addr_q <= gpr_addr;
			pend_dest_q <= br_target;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			jc_valid_q <= 1'b0;
			jc_tag_q <= '0;
		end else if (accept && br_go) begin
			jc_valid_q <= 1'b1;
			jc_tag_q <= br_pc;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cp_q <= CP_RST;
			sp_q <= SP_RST;
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
		end else begin
			cp_q <= cp_wr ? cp_next : cp_q;
			sp_q <= sp_d;
			// A new event beats a clear in the same cycle
			ovf_q <= ovf_ev | (ovf_q & ~stk_flag_clr);
			unf_q <= unf_ev | (unf_q & ~stk_flag_clr);
		end
	end

	// ---------------------------------------------------------------
	// Retire: results, writeback, branch, coprocessor outputs
	// ---------------------------------------------------------------
	wire stk_ram = do_push || do_pop;
	wire fin_we = busy ? pend_we_q : ex_we;
	wire fin_br = busy ? pend_br_q : br_go;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			res_valid <= 1'b0;
			res_data <= '0;
			res_hi <= '0;
			br_redirect <= 1'b0;
			br_dest <= '0;
			ram_we <= 1'b0;
			ram_re <= 1'b0;
			ram_addr <= '0;
			ram_wdata <= '0;
		end else begin
			res_valid <= finish;
			br_redirect <= finish && fin_br;
			ram_we <= (finish && fin_we) || do_push;
			ram_re <= do_pop;
			if (finish) begin
				res_data <= busy ? pend_res_q : ex_res;
				res_hi <= busy ? pend_hi_q : ex_hi;
				br_dest <= busy ? pend_dest_q : br_target;
			end
			if (stk_ram) begin
				ram_addr <= do_push ? sp_dec : sp_q;
				ram_wdata <= src_a;
			end else if (finish) begin
				ram_addr <= busy ? pend_addr_q : gpr_addr;
				ram_wdata <= busy ? pend_res_q : ex_res;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mac_strobe <= 1'b0;
			mac_op1 <= '0;
			mac_op2 <= '0;
			mac_acc <= '0;
			stage_q <= '0;
		end else begin
			mac_strobe <= accept && is_mac;
			if (accept && is_mac) begin
				mac_op1 <= src_a;
				mac_op2 <= src_b;
			end
			if (mac_step) mac_acc <= acc_d;
			stage_q <= {stage_q[PIPE_STAGES-2:0], accept};
		end
	end

	assign context_base_pointer = cp_q;
	assign stack_pointer = sp_q;
	assign stk_ovf_flag = ovf_q;
	assign stk_unf_flag = unf_q;
	assign stage_valid = stage_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_mul_five_cycles: assert property (accept && issue_op == OP_MUL |->
		##1 (!issue_ready)[*4] ##1 (issue_ready && res_valid))
		else $error("multiply result not after five cycles");
	a_div_ten_cycles: assert property (accept && issue_op == OP_DIV |->
		##1 (!issue_ready)[*8] ##1 (!issue_ready && !res_valid) ##1 (issue_ready && res_valid))
		else $error("divide result not after ten cycles");
	a_branch_two_cycles: assert property (accept && br_go && !jc_hit |->
		##1 !issue_ready ##1 br_redirect)
		else $error("uncached branch not two cycles");
	a_jcache_one_cycle: assert property (accept && br_go && jc_hit |->
		##1 (br_redirect && issue_ready))
		else $error("cached branch not one cycle");
	a_shift_one_cycle: assert property (accept && issue_op == OP_SHIFT |->
		##1 (res_valid && issue_ready))
		else $error("shift not single cycle");
	a_busy_stalls: assert property (busy |-> !issue_ready)
		else $error("issue open during multi-cycle op");
	a_gpr_address: assert property (accept && issue_op == OP_ALU |->
		##1 (ram_we && ram_addr == $past(cp_q) + {11'h000, $past(dst_sel), 1'b0}))
		else $error("register address not from base pointer");
	a_stack_overflow: assert property (ovf_ev |-> ##1 stk_ovf_flag[*2])
		else $error("overflow event lost");
	a_stack_underflow: assert property (unf_ev && !do_push |=> stk_unf_flag)
		else $error("underflow not flagged");
	a_mac_operands: assert property (accept && is_mac |=>
		mac_strobe && mac_op1 == $past(src_a) && mac_op2 == $past(src_b))
		else $error("coprocessor operands not delivered");
	a_stack_window: assert property ((stack_pointer & ~STACK_MASK) == STACK_BASE
		|| $past(sp_wr)) else $error("stack pointer left its window");

	c_mul_issue: cover property (accept && issue_op == OP_MUL ##5 res_valid);
	c_jcache_hit: cover property (accept && br_go && jc_hit);
	c_stack_ovf: cover property (ovf_ev ##1 stk_ovf_flag);
	c_mac_repeat: cover property (accept && is_mac && mac_repeat != 4'h0);
endmodule

// ===== verification/cxc_ram_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Internal work RAM seen from the core's RAM port
// ---------------------------------------------------------------
module cxc_ram_model (
	input wire logic clk,
	input wire logic ram_we,
	input wire logic ram_re,
	input wire logic [15:0] ram_addr,
	input wire logic [15:0] ram_wdata
);
	logic [15:0] mem [logic [15:0]];
	int reads;
	// Registers and stack share one store, so banks may overlap freely
	always @(posedge clk) begin
		if (ram_we === 1'b1) begin
			mem[ram_addr] = ram_wdata;
		end
		if (ram_re === 1'b1) begin
			reads++;
		end
	end
	// Unwritten words read as unknown, so a missed write never matches
	function automatic logic [15:0] rd(input logic [15:0] a);
		return mem.exists(a) ? mem[a] : 16'hXXXX;
	endfunction
endmodule

// ===== verification/tb_cpu_core_execution_context.sv
`timescale 1ns/1ns
module tb_cpu_core_execution_context;
	import cxc_pkg::*;
	typedef struct {logic [3:0] op; logic [1:0] fn; logic [15:0] a, b, h;
		logic [3:0] s; int l; logic [15:0] el, eh;} cxc_row_t;
	logic clk, nrst, issue_valid, br_taken, cp_wr, sp_wr, stk_flag_clr;
	logic [3:0] issue_op, shift_amt, dst_sel, mac_repeat;
	logic [1:0] issue_fn;
	logic [15:0] src_a, src_b, src_hi, br_pc, br_target, cp_wdata, sp_wdata;
	logic [15:0] stack_upper_bound, stack_lower_bound;
	logic issue_ready, stk_ovf_flag, stk_unf_flag, res_valid, br_redirect;
	logic ram_we, ram_re, mac_strobe;
	logic [15:0] context_base_pointer, stack_pointer, res_data, res_hi, br_dest;
	logic [15:0] ram_addr, ram_wdata, mac_op1, mac_op2;
	logic [MAC_ACC_W-1:0] mac_acc;
	logic [PIPE_STAGES-1:0] stage_valid;
	int bad_count, checked, lat;
	cxc_row_t rows [15];
	cxc_core dut (.clk, .nrst, .issue_valid, .issue_ready, .issue_op, .issue_fn,
		.src_a, .src_b, .src_hi, .shift_amt, .dst_sel, .mac_repeat, .br_taken,
		.br_pc, .br_target, .cp_wr, .cp_wdata, .sp_wr, .sp_wdata,
		.stack_upper_bound, .stack_lower_bound, .stk_flag_clr,
		.context_base_pointer, .stack_pointer, .stk_ovf_flag, .stk_unf_flag,
		.res_valid, .res_data, .res_hi, .br_redirect, .br_dest, .ram_we, .ram_re,
		.ram_addr, .ram_wdata, .mac_strobe, .mac_op1, .mac_op2, .mac_acc,
		.stage_valid);
	cxc_ram_model ram (.clk, .ram_we, .ram_re, .ram_addr, .ram_wdata);
	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task chk(input logic [15:0] g, input logic [15:0] e, input string m);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask
	task chkn(input int g, input int e, input string m);
		checked++;
		if (g != e) begin
			bad_count++;
			$display("wrong value at %0t: %s took %0d want %0d", $time, m, g, e);
		end
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// One issue, then count edges to the answer; bounded so a hang cannot stall
	task issue(input logic [3:0] op, input logic [1:0] fn, input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] h, input logic [3:0] s,
		input logic [3:0] d);
		@(posedge clk);
		#1;
		issue_valid = 1'b1;
		issue_op = op;
		issue_fn = fn;
		src_a = a;
		src_b = b;
		src_hi = h;
		shift_amt = s;
		dst_sel = d;
		@(posedge clk);
		#1;
		issue_valid = 1'b0;
		lat = 1;
		while ((res_valid | br_redirect) !== 1'b1 && lat < 20) begin
			@(posedge clk);
			#1;
			lat++;
		end
	endtask
	task tick;
		@(posedge clk);
		#1;
	endtask
	// ---------------------------------------------------------------
	// Stimulus
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#20000;
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		report_and_stop();
	end
	initial begin
		{issue_valid, br_taken, cp_wr, sp_wr, stk_flag_clr, nrst} = 6'h00;
		{issue_op, shift_amt, dst_sel, mac_repeat, issue_fn} = 18'h00000;
		{src_a, src_b, src_hi, br_pc, br_target, cp_wdata, sp_wdata} = 112'h0;
		stack_upper_bound = 16'hF000;
		stack_lower_bound = 16'hF7FE;
		rows = '{'{OP_ALU, FN_ADD, 16'h1234, 16'h4321, 16'h0000, 4'h0, 1, 16'h5555, 16'h0000},
			'{OP_ALU, FN_SUB, 16'h0001, 16'h0002, 16'h0000, 4'h0, 1, 16'hFFFF, 16'h0000},
			'{OP_ALU, FN_AND, 16'hF0F0, 16'h3C3C, 16'h0000, 4'h0, 1, 16'h3030, 16'h0000},
			'{OP_ALU, FN_OR, 16'hF0F0, 16'h0F0F, 16'h0000, 4'h0, 1, 16'hFFFF, 16'h0000},
			'{OP_SHIFT, FN_SHL, 16'h0001, 16'h0000, 16'h0000, 4'hF, 1, 16'h8000, 16'h0000},
			'{OP_SHIFT, FN_SHR, 16'h8000, 16'h0000, 16'h0000, 4'hF, 1, 16'h0001, 16'h0000},
			'{OP_SHIFT, FN_ROL, 16'h8001, 16'h0000, 16'h0000, 4'h1, 1, 16'h0003, 16'h0000},
			'{OP_SHIFT, FN_ASHR, 16'h8000, 16'h0000, 16'h0000, 4'hF, 1, 16'hFFFF, 16'h0000},
			'{OP_BIT, 2'h0, 16'h0000, 16'h0000, 16'h0000, 4'h5, 1, 16'h0020, 16'h0000},
			'{OP_BIT, 2'h1, 16'hFFFF, 16'h0000, 16'h0000, 4'h0, 1, 16'hFFFE, 16'h0000},
			'{OP_MUL, 2'h0, 16'hFFFF, 16'hFFFF, 16'h0000, 4'h0, 5, 16'h0001, 16'hFFFE},
			'{OP_MUL, 2'h1, 16'hFFFF, 16'h0002, 16'h0000, 4'h0, 5, 16'hFFFE, 16'hFFFF},
			'{OP_DIV, 2'h0, 16'h0000, 16'h0010, 16'h0001, 4'h0, 10, 16'h1000, 16'h0000},
			'{OP_DIV, 2'h0, 16'h1234, 16'h0000, 16'h0000, 4'h0, 10, 16'hFFFF, 16'h1234},
			'{OP_MUL, 2'h1, 16'h8000, 16'h0002, 16'h0000, 4'h0, 5, 16'h0000, 16'hFFFF}};
		repeat (6) @(posedge clk);
		#1;
		nrst = 1'b1;
		chk(context_base_pointer, 16'hFC00, "reset cp");
		chk(stack_pointer, 16'hF7FE, "reset sp");
		chk({14'h0000, stk_ovf_flag, stk_unf_flag}, 16'h0000, "reset flags");
		chk({15'h0000, issue_ready}, 16'h0001, "reset ready");
		$display("test reset done");
		for (int i = 0; i < 15; i++) begin
			issue(rows[i].op, rows[i].fn, rows[i].a, rows[i].b, rows[i].h, rows[i].s, 4'(i));
			chkn(lat, rows[i].l, "latency");
			chk(res_data, rows[i].el, "result");
			chk(res_hi, rows[i].eh, "high word");
			chk(ram_addr, 16'hFC00 + 16'(2 * i), "reg addr");
			tick();
			chk(ram.rd(16'hFC00 + 16'(2 * i)), rows[i].el, "reg ram");
		end
		$display("test table done");
		// A repeated jump address hits the single cache entry; a new one misses
		br_taken = 1'b1;
		br_target = 16'h0200;
		for (int i = 0; i < 3; i++) begin
			br_pc = (i == 2) ? 16'h0300 : 16'h0100;
			issue(OP_BRANCH, 2'h0, 16'h0000, 16'h0000, 16'h0000, 4'h0, 4'h0);
			chkn(lat, (i == 1) ? 1 : 2, "branch");
			chk(br_dest, 16'h0200, "branch dest");
		end
		br_taken = 1'b0;
		$display("test branch done");
		cp_wr = 1'b1;
		cp_wdata = 16'h0201;
		tick();
		cp_wr = 1'b0;
		chk(context_base_pointer, 16'h0200, "cp load");
		issue(OP_ALU, FN_OR, 16'h00A5, 16'h5A00, 16'h0000, 4'h0, 4'h3);
		chk(ram_addr, 16'h0206, "bank addr");
		$display("test context done");
		stack_upper_bound = 16'hF7FD;
		issue(OP_PUSH, 2'h0, 16'hABCD, 16'h0000, 16'h0000, 4'h0, 4'h0);
		chk(ram_addr, 16'hF7FC, "push addr");
		chk(ram_wdata, 16'hABCD, "push data");
		repeat (2) tick();
		chk(stack_pointer, 16'hF7FC, "push sp");
		chk(ram.rd(16'hF7FC), 16'hABCD, "push ram");
		chk({14'h0000, stk_ovf_flag, stk_unf_flag}, 16'h0002, "overflow");
		stk_flag_clr = 1'b1;
		tick();
		stk_flag_clr = 1'b0;
		tick();
		chk({15'h0000, stk_ovf_flag}, 16'h0000, "flag clear");
		stack_lower_bound = 16'hF7FC;
		issue(OP_POP, 2'h0, 16'h0000, 16'h0000, 16'h0000, 4'h0, 4'h0);
		chk(ram_addr, 16'hF7FC, "pop addr");
		repeat (2) tick();
		chk(stack_pointer, 16'hF7FE, "pop sp");
		chkn(ram.reads, 1, "pop read");
		chk({14'h0000, stk_ovf_flag, stk_unf_flag}, 16'h0001, "underflow");
		sp_wr = 1'b1;
		sp_wdata = 16'hF100;
		tick();
		sp_wr = 1'b0;
		chk(stack_pointer, 16'hF100, "sp load");
		$display("test stack done");
		// Repeat unit runs the accumulate three times, the first on the issued operands, the last two on latched ones
		mac_repeat = 4'h2;
		issue(OP_MAC, FN_MAC_ACC, 16'h0003, 16'h0004, 16'h0000, 4'h0, 4'h0);
		chkn(lat, 3, "mac");
		chk(mac_op1, 16'h0003, "mac op1");
		chk(mac_op2, 16'h0004, "mac op2");
		chk(mac_acc[15:0], 16'h0024, "mac acc");
		// Signed 32-bit add sign-extends into the guard bits of the accumulator
		mac_repeat = 4'h0;
		issue(OP_MAC, FN_MAC_ADD32, 16'h0001, 16'hFFFF, 16'h0000, 4'h0, 4'h0);
		chkn(lat, 1, "mac single");
		chk(mac_acc[39:24], 16'hFFFF, "add32 sign");
		chk(mac_acc[15:0], 16'h0025, "add32 low");
		issue(OP_MAC, FN_MAC_MUL, 16'h8000, 16'h0002, 16'h0000, 4'h0, 4'h0);
		chk({15'h0000, mac_strobe}, 16'h0001, "mac strobe");
		chk(mac_acc[31:16], 16'hFFFF, "mac mul high");
		chk(mac_acc[15:0], 16'h0000, "mac mul low");
		chk({12'h000, stage_valid}, 16'h0005, "stages");
		$display("test mac done");
		// Reset in mid-run clears state at once and the core takes work again
		nrst = 1'b0;
		tick();
		chk(context_base_pointer, 16'hFC00, "rerun cp");
		chk(stack_pointer, 16'hF7FE, "rerun sp");
		chk({14'h0000, stk_ovf_flag, stk_unf_flag}, 16'h0000, "rerun flags");
		chk(mac_acc[31:16], 16'h0000, "rerun acc");
		nrst = 1'b1;
		issue(OP_ALU, FN_ADD, 16'h0001, 16'h0001, 16'h0000, 4'h0, 4'h1);
		chkn(lat, 1, "rerun latency");
		chk(ram_addr, 16'hFC02, "rerun addr");
		$display("test rerun done");
		report_and_stop();
	end
endmodule
